// [rtl/gax_regs.sv]
// Channel-1 auxiliary register bank with AXI4-Lite slave and serial frame engine
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module gax_regs (
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   input wire logic [9:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [9:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic DCL_I,
   input wire logic FSC_I,
   input wire logic DD_I,
   input wire logic MON0_CHANGE_I,
   output logic DU_O,
   output logic IRQ_O
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic aw_got_q, w_got_q;
   logic [7:0] aw_idx_q;
   logic [7:0] w_byte_q;
   logic w_lane0_q;
   logic wr_fire;
   logic ar_fire;
   logic [7:0] ar_idx;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic rd_clr_mon1, rd_clr_ext;
   logic [7:0] mon1_receive_byte_q, mon1_transmit_byte_q;
   logic [7:0] ic1_receive_byte_q, ic2_receive_byte_q;
   logic [7:0] ic1_transmit_byte_q, ic2_transmit_byte_q;
   logic [3:0] monitor1_control_q;
   logic [7:0] aux_ext_int_mask_q;
   logic [7:0] aux_ext_int_status_q;
   gax_pkg::gax_mon1_flags_t monitor1_int_status_q;
   gax_pkg::gax_mon1_flags_t mon1_set;
   logic mon1_transmit_active_q;
   logic [5:0] ci1_indication_q, ci1_command_q;
   logic [2:0] dcl_s, fsc_s;
   logic [1:0] dd_s;
   logic dcl_rise, dcl_fall, fsc_rise;
   logic [5:0] bit_cnt_q;
   logic [7:0] rx_sh_q;
   logic [7:0] rx_byte;
   logic slot_end;
   logic [7:0] mon1_cand_q;
   logic [7:0] tx_octet;
   logic rx_mr, rx_mx;
   logic mx_prev_q, mr_prev_q, in_pkt_q, mr_ack_q;
   logic new_byte, end_rx, ack_seen, abort_seen, ci1_eval;
   logic mr_tx_q, mx_tx_q;
   logic [7:0] ext_set;
   logic rie, rbc, xie, xbc;

   assign rie = monitor1_control_q[gax_pkg::CTL_RX_INT_ENABLE];
   assign rbc = monitor1_control_q[gax_pkg::CTL_RX_BIT_CONTROL];
   assign xie = monitor1_control_q[gax_pkg::CTL_TX_INT_ENABLE];
   assign xbc = monitor1_control_q[gax_pkg::CTL_TX_BIT_CONTROL];

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   assign wr_fire = aw_got_q && w_got_q && !S_AXI_BVALID_O;

   // Address and data taken in either order, response after both
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_idx_q <= 8'h00;
         w_byte_q <= 8'h00;
         w_lane0_q <= 1'b0;
         S_AXI_AWREADY_O <= 1'b1;
         S_AXI_WREADY_O <= 1'b1;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= gax_pkg::RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_got_q <= 1'b1;
            aw_idx_q <= S_AXI_AWADDR_I[9:2];
            S_AXI_AWREADY_O <= 1'b0;
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_got_q <= 1'b1;
            w_byte_q <= S_AXI_WDATA_I[7:0];
            w_lane0_q <= S_AXI_WSTRB_I[0];
            S_AXI_WREADY_O <= 1'b0;
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= wr_hit(aw_idx_q) ? gax_pkg::RESP_OKAY : gax_pkg::RESP_SLVERR;
         end
         if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O <= 1'b1;
         end
      end
   end

   // Writable register indexes
   function automatic logic wr_hit(input logic [7:0] idx);
      wr_hit = (idx == gax_pkg::IDX_MON1_TRANSMIT_BYTE) || (idx == gax_pkg::IDX_IC1_TRANSMIT_BYTE) ||
               (idx == gax_pkg::IDX_IC2_TRANSMIT_BYTE) || (idx == gax_pkg::IDX_MONITOR1_CONTROL) ||
               (idx == gax_pkg::IDX_AUX_EXT_INT_MASK) || (idx == gax_pkg::IDX_MON1_TX_ACTIVE) ||
               (idx == gax_pkg::IDX_CI1_COMMAND);
   endfunction : wr_hit

   // Software-written registers
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         mon1_transmit_byte_q <= gax_pkg::RST_BYTE_ONES;
         ic1_transmit_byte_q <= gax_pkg::RST_BYTE_ONES;
         ic2_transmit_byte_q <= gax_pkg::RST_BYTE_ONES;
         monitor1_control_q <= gax_pkg::RST_MONITOR1_CONTROL;
         aux_ext_int_mask_q <= gax_pkg::RST_AUX_EXT_INT_MASK;
         ci1_command_q <= gax_pkg::RST_CI1_COMMAND;
      end else if (wr_fire && w_lane0_q) begin
         unique case (aw_idx_q)
            gax_pkg::IDX_MON1_TRANSMIT_BYTE: mon1_transmit_byte_q <= w_byte_q;
            gax_pkg::IDX_IC1_TRANSMIT_BYTE: ic1_transmit_byte_q <= w_byte_q;
            gax_pkg::IDX_IC2_TRANSMIT_BYTE: ic2_transmit_byte_q <= w_byte_q;
            gax_pkg::IDX_MONITOR1_CONTROL: monitor1_control_q <= w_byte_q[3:0];
            gax_pkg::IDX_AUX_EXT_INT_MASK: begin
               // Fixed bits forced regardless of data
               aux_ext_int_mask_q <= (w_byte_q & gax_pkg::MASK_WRITABLE) | gax_pkg::MASK_FIXED_ONES;
            end
            gax_pkg::IDX_CI1_COMMAND: ci1_command_q <= w_byte_q[5:0];
            default: ;
         endcase
      end
   end

   // Transmit-active: software sets, acknowledge clears
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         mon1_transmit_active_q <= 1'b0;
      end else if (wr_fire && w_lane0_q && aw_idx_q == gax_pkg::IDX_MON1_TX_ACTIVE
                   && w_byte_q[gax_pkg::ACT_TX_ACTIVE]) begin
         mon1_transmit_active_q <= 1'b1;
      end else if (ack_seen) begin
         mon1_transmit_active_q <= 1'b0;
      end
   end

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   assign ar_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   assign ar_idx = S_AXI_ARADDR_I[9:2];
   assign rd_clr_mon1 = ar_fire && ar_idx == gax_pkg::IDX_MONITOR1_INT_STATUS;
   assign rd_clr_ext = ar_fire && ar_idx == gax_pkg::IDX_AUX_EXT_INT_STATUS;

   // Read data multiplexer
   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      unique case (ar_idx)
         gax_pkg::IDX_MON1_RECEIVE_BYTE: rd_byte = mon1_receive_byte_q;
         gax_pkg::IDX_IC1_RECEIVE_BYTE: rd_byte = ic1_receive_byte_q;
         gax_pkg::IDX_IC2_RECEIVE_BYTE: rd_byte = ic2_receive_byte_q;
         gax_pkg::IDX_MON1_TRANSMIT_BYTE: rd_byte = mon1_transmit_byte_q;
         gax_pkg::IDX_IC1_TRANSMIT_BYTE: rd_byte = ic1_transmit_byte_q;
         gax_pkg::IDX_IC2_TRANSMIT_BYTE: rd_byte = ic2_transmit_byte_q;
         gax_pkg::IDX_MONITOR1_INT_STATUS: rd_byte = {4'h0, monitor1_int_status_q};
         gax_pkg::IDX_AUX_EXT_INT_STATUS: rd_byte = aux_ext_int_status_q;
         gax_pkg::IDX_MONITOR1_CONTROL: rd_byte = {4'h0, monitor1_control_q};
         gax_pkg::IDX_AUX_EXT_INT_MASK: rd_byte = aux_ext_int_mask_q;
         gax_pkg::IDX_MON1_TX_ACTIVE: rd_byte = {1'b0, mon1_transmit_active_q, 6'h00};
         gax_pkg::IDX_CI1_INDICATION: rd_byte = {2'h0, ci1_indication_q};
         gax_pkg::IDX_CI1_COMMAND: rd_byte = {2'h0, ci1_command_q};
         default: rd_hit = 1'b0;
      endcase
   end

   // One read at a time, data one cycle after address
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         S_AXI_ARREADY_O <= 1'b1;
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= 32'h0000_0000;
         S_AXI_RRESP_O <= gax_pkg::RESP_OKAY;
      end else if (ar_fire) begin
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RDATA_O <= {24'h00_0000, rd_byte};
         S_AXI_RRESP_O <= rd_hit ? gax_pkg::RESP_OKAY : gax_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_ARREADY_O <= 1'b1;
      end
   end

   // ****************************************************************
   // Link pin synchronisers and bit timing
   // ****************************************************************
   // Two flops per pin, third stage only for edge finding
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         dcl_s <= 3'h0;
         fsc_s <= 3'h0;
         dd_s <= 2'h3;
      end else begin
         dcl_s <= {dcl_s[1:0], DCL_I};
         fsc_s <= {fsc_s[1:0], FSC_I};
         dd_s <= {dd_s[0], DD_I};
      end
   end

   assign dcl_rise = dcl_s[1] && !dcl_s[2];
   assign dcl_fall = !dcl_s[1] && dcl_s[2];
   assign fsc_rise = fsc_s[1] && !fsc_s[2];
   assign rx_byte = {rx_sh_q[6:0], dd_s[1]};
   assign slot_end = dcl_fall && bit_cnt_q[2:0] == 3'h7;
   assign rx_mr = rx_byte[1];
   assign rx_mx = rx_byte[0];

   // Bit position: frame sync restarts, falling clock advances
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         bit_cnt_q <= 6'h00;
         rx_sh_q <= 8'hff;
      end else if (fsc_rise) begin
         bit_cnt_q <= 6'h00;
      end else if (dcl_fall) begin
         rx_sh_q <= rx_byte;
         bit_cnt_q <= bit_cnt_q + 6'h01;
      end
   end

   // Transmit octet for the current slot
   always_comb begin
      unique case (bit_cnt_q[5:3])
         gax_pkg::SLOT_IC1: tx_octet = ic1_transmit_byte_q;
         gax_pkg::SLOT_IC2: tx_octet = ic2_transmit_byte_q;
         gax_pkg::SLOT_MON1: tx_octet = mon1_transmit_byte_q;
         gax_pkg::SLOT_CI1: tx_octet = {ci1_command_q, mr_tx_q, mx_tx_q};
         default: tx_octet = gax_pkg::RST_BYTE_ONES;
      endcase
   end

   // Upstream bit driven on the rising link clock, MSB first
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         DU_O <= 1'b1;
      end else if (dcl_rise) begin
         DU_O <= tx_octet[3'h7 - bit_cnt_q[2:0]];
      end
   end

   // ****************************************************************
   // Received slot capture
   // ****************************************************************
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         ic1_receive_byte_q <= 8'h00;
         ic2_receive_byte_q <= 8'h00;
         mon1_cand_q <= 8'hff;
      end else if (slot_end) begin
         if (bit_cnt_q[5:3] == gax_pkg::SLOT_IC1) ic1_receive_byte_q <= rx_byte;
         if (bit_cnt_q[5:3] == gax_pkg::SLOT_IC2) ic2_receive_byte_q <= rx_byte;
         if (bit_cnt_q[5:3] == gax_pkg::SLOT_MON1) mon1_cand_q <= rx_byte;
      end
   end

   assign ci1_eval = slot_end && bit_cnt_q[5:3] == gax_pkg::SLOT_CI1;

   // CI1 indication field
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         ci1_indication_q <= 6'h3f;
      end else if (ci1_eval) begin
         ci1_indication_q <= rx_byte[7:2];
      end
   end

   // ****************************************************************
   // Monitor channel 1 handshake
   // ****************************************************************
   assign new_byte = ci1_eval && !rx_mx && mx_prev_q;
   assign end_rx = ci1_eval && rx_mx && mx_prev_q && in_pkt_q;
   assign ack_seen = ci1_eval && mon1_transmit_active_q && xbc && !rx_mr && mr_prev_q;
   assign abort_seen = ci1_eval && !mon1_transmit_active_q && xbc && !rx_mr && mr_prev_q;

   // Receive side packet state and stored byte
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         mx_prev_q <= 1'b1;
         mr_prev_q <= 1'b1;
         in_pkt_q <= 1'b0;
         mr_ack_q <= 1'b0;
         mon1_receive_byte_q <= gax_pkg::RST_BYTE_ONES;
      end else if (ci1_eval) begin
         mx_prev_q <= rx_mx;
         mr_prev_q <= rx_mr;
         if (new_byte) begin
            mon1_receive_byte_q <= mon1_cand_q;
            in_pkt_q <= 1'b1;
            mr_ack_q <= 1'b1;
         end else if (rx_mx) begin
            mr_ack_q <= 1'b0;
         end
         if (end_rx) in_pkt_q <= 1'b0;
      end
   end

   // Handshake bits: MR low acknowledges, MX low offers data
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         mr_tx_q <= 1'b1;
         mx_tx_q <= 1'b1;
      end else begin
         mr_tx_q <= !(rbc && mr_ack_q);
         mx_tx_q <= !(xbc && mon1_transmit_active_q);
      end
   end

   // Flag sources, gated by the interrupt enables
   always_comb begin
      mon1_set.data_received = new_byte && rie && (rbc || !in_pkt_q);
      mon1_set.end_of_reception = end_rx && rie;
      mon1_set.data_acknowledged = ack_seen && xie;
      mon1_set.abort = abort_seen && xie;
   end

   // Sticky status, set wins over read-clear
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         monitor1_int_status_q <= '0;
      end else begin
         monitor1_int_status_q <= (rd_clr_mon1 ? '0 : monitor1_int_status_q) | mon1_set;
      end
   end

   // ****************************************************************
   // Extended interrupt status and output
   // ****************************************************************
   always_comb begin
      ext_set = 8'h00;
      ext_set[gax_pkg::EXT_MON1_CHANGE] = |mon1_set || new_byte;
      ext_set[gax_pkg::EXT_MON0_CHANGE] = MON0_CHANGE_I;
      ext_set[gax_pkg::EXT_IC1_SLOT] = slot_end && bit_cnt_q[5:3] == gax_pkg::SLOT_IC1;
      ext_set[gax_pkg::EXT_IC2_SLOT] = slot_end && bit_cnt_q[5:3] == gax_pkg::SLOT_IC2;
      ext_set[gax_pkg::EXT_CI1_CHANGE] = ci1_eval && rx_byte[7:2] != ci1_indication_q;
   end

   // Masked sources never set, read clears, set wins
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         aux_ext_int_status_q <= 8'h00;
      end else begin
         aux_ext_int_status_q <= (rd_clr_ext ? 8'h00 : aux_ext_int_status_q)
                                 | (ext_set & ~aux_ext_int_mask_q);
      end
   end

   // Interrupt output
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= |(aux_ext_int_status_q & ~aux_ext_int_mask_q);
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);

   a_mon1_read_clears: assert property (rd_clr_mon1 && mon1_set == '0 |=> monitor1_int_status_q == '0)
      else $error("monitor-1 status not cleared by read");
   a_ack_sets_flag: assert property (ack_seen && xie |=> monitor1_int_status_q.data_acknowledged)
      else $error("acknowledge did not set flag");
   a_rx_enable_gates: assert property ($rose(monitor1_int_status_q.data_received) |-> $past(rie))
      else $error("receive flag set while disabled");
   a_mr_held_high: assert property (!rbc [*2] |-> mr_tx_q)
      else $error("MR not held high");
   a_mr_acks_byte: assert property (new_byte && rbc ##1 rbc |=> !mr_tx_q)
      else $error("MR did not acknowledge byte");
   a_tx_enable_gates: assert property ($rose(monitor1_int_status_q.abort) |-> $past(xie))
      else $error("abort flag set while disabled");
   a_mx_idle_high: assert property (!xbc [*2] |-> mx_tx_q)
      else $error("MX not held high");
   a_mask_fixed_bits: assert property (aux_ext_int_mask_q[7:5] == 3'h7 && !aux_ext_int_mask_q[3])
      else $error("mask fixed bits wrong");
   a_ic1_slot_event: assert property (ext_set[2] && !aux_ext_int_mask_q[2] |=> aux_ext_int_status_q[2])
      else $error("IC1 slot event lost");
   a_irq_unmasked: assert property (aux_ext_int_status_q[3] |=> IRQ_O)
      else $error("interrupt not raised");

   c_byte_received: cover property (new_byte ##[1:1000] end_rx);
   c_tx_acked: cover property (ack_seen);
   c_ci1_change: cover property (ext_set[0] ##[1:50] rd_clr_ext);

endmodule : gax_regs

// [inc/gax_pkg.sv]
// Constants, field layouts and carrier types of the channel-1 auxiliary register bank
package gax_pkg;

   // ****************************************************************
   // Register indexes (byte address is four times the index)
   // ****************************************************************
   localparam logic [7:0] IDX_MON1_RECEIVE_BYTE = 8'h6d;
   localparam logic [7:0] IDX_IC1_RECEIVE_BYTE = 8'h6e;
   localparam logic [7:0] IDX_IC2_RECEIVE_BYTE = 8'h6f;
   localparam logic [7:0] IDX_MON1_TRANSMIT_BYTE = 8'h71;
   localparam logic [7:0] IDX_IC1_TRANSMIT_BYTE = 8'h72;
   localparam logic [7:0] IDX_IC2_TRANSMIT_BYTE = 8'h73;
   localparam logic [7:0] IDX_MONITOR1_INT_STATUS = 8'h75;
   localparam logic [7:0] IDX_AUX_EXT_INT_STATUS = 8'h76;
   localparam logic [7:0] IDX_MONITOR1_CONTROL = 8'h79;
   localparam logic [7:0] IDX_AUX_EXT_INT_MASK = 8'h7a;
   localparam logic [7:0] IDX_MON1_TX_ACTIVE = 8'h7c;
   localparam logic [7:0] IDX_CI1_INDICATION = 8'h7d;
   localparam logic [7:0] IDX_CI1_COMMAND = 8'h7e;

   // ****************************************************************
   // Reset values and field positions
   // ****************************************************************
   localparam logic [7:0] RST_BYTE_ONES = 8'hff;
   localparam logic [3:0] RST_MONITOR1_CONTROL = 4'h0;
   localparam logic [7:0] RST_AUX_EXT_INT_MASK = 8'hf7;
   localparam logic [7:0] MASK_FIXED_ONES = 8'he0;
   localparam logic [7:0] MASK_WRITABLE = 8'h17;
   localparam logic [5:0] RST_CI1_COMMAND = 6'h3f;
   localparam int CTL_RX_INT_ENABLE = 3;
   localparam int CTL_RX_BIT_CONTROL = 2;
   localparam int CTL_TX_INT_ENABLE = 1;
   localparam int CTL_TX_BIT_CONTROL = 0;
   localparam int ACT_TX_ACTIVE = 6;
   localparam int EXT_MON1_CHANGE = 4;
   localparam int EXT_MON0_CHANGE = 3;
   localparam int EXT_IC1_SLOT = 2;
   localparam int EXT_IC2_SLOT = 1;
   localparam int EXT_CI1_CHANGE = 0;

   // ****************************************************************
   // Serial frame layout: eight octets, MSB first
   // ****************************************************************
   localparam logic [2:0] SLOT_IC1 = 3'h4;
   localparam logic [2:0] SLOT_IC2 = 3'h5;
   localparam logic [2:0] SLOT_MON1 = 3'h6;
   localparam logic [2:0] SLOT_CI1 = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Monitor-1 status flags, packed in register bit order
   typedef struct packed {
      logic data_received;
      logic end_of_reception;
      logic data_acknowledged;
      logic abort;
   } gax_mon1_flags_t;

endpackage : gax_pkg

// [tb/gax_link_model.sv]
// Far-side serial bus device: clocks frames and captures the upstream octets
`timescale 1ns/1ps
module gax_link_model (
   output logic dcl_o,
   output logic fsc_o,
   output logic dd_o,
   input wire logic du_i
);
   logic [63:0] du_frame;
   // Idle: clock stands still, no frame sync
   initial begin
      dcl_o = 1'b0;
      fsc_o = 1'b0;
      dd_o = 1'b1;
      du_frame = '0;
   end
   // One 64-bit frame, MSB first, data launched at clock rise
   task automatic send(input logic [63:0] f);
      #3;
      for (int i = 63; i >= 0; i--) begin
         dcl_o = 1'b1;
         fsc_o = (i == 63);
         dd_o = f[i];
         #80;
         dcl_o = 1'b0;
         du_frame[i] = du_i; // Upstream settled well before the fall
         #80;
      end
      fsc_o = 1'b0;
      dd_o = ~dd_o; // Released line shows no stale bit
   endtask : send
endmodule : gax_link_model

// [tb/gax_regs_tb.sv]
// Self-checking bench of the channel-1 auxiliary register bank
`timescale 1ns/1ps
module gax_regs_tb;
   logic clk = 1'b0, rn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, mon0 = 1'b0;
   logic awr, wr, arr, bv, rv, dcl, fsc, dd, du, irq;
   logic [9:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [1:0] bresp, rresp, rsp;
   logic [7:0] mdl [logic [7:0]];
   logic [7:0] ic1, ic2, m;
   logic [5:0] ci;
   int num_errors = 0;
   int total_checks = 0;
   always #4 clk = ~clk;
   gax_regs uut (.CLOCK_I(clk), .RESETN_I(rn), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv),
      .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
      .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1), .DCL_I(dcl), .FSC_I(fsc),
      .DD_I(dd), .MON0_CHANGE_I(mon0), .DU_O(du), .IRQ_O(irq));
   gax_link_model lnk (.dcl_o(dcl), .fsc_o(fsc), .dd_o(dd), .du_i(du));
   // ****************************************************************
   // Bus cycles, compare and closing tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Waits for the answer however long it takes; only the watchdog ends a hang
   task automatic axw(input logic [7:0] i, input logic [7:0] v, output logic [1:0] r);
      logic a, w, b;
      awaddr <= {i, 2'b00};
      wdata <= {24'h0, v};
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(negedge clk);
         a = awv & awr;
         w = wv & wr;
         b = bv;
         r = bresp;
         @(posedge clk);
         if (a) awv <= 1'b0;
         if (w) wv <= 1'b0;
      end while (!b);
   endtask : axw
   task automatic axr(input logic [7:0] i, output logic [31:0] v, output logic [1:0] r);
      logic a, b;
      araddr <= {i, 2'b00};
      arv <= 1'b1;
      do begin
         @(negedge clk);
         a = arv & arr;
         b = rv;
         v = rdata;
         r = rresp;
         @(posedge clk);
         if (a) arv <= 1'b0;
      end while (!b);
   endtask : axr
   task automatic rc(input logic [7:0] i, input logic [7:0] e);
      logic [31:0] v;
      axr(i, v, rsp);
      chk({rsp, v[29:0]}, {24'h0, e});
   endtask : rc
   // Expected read-back of a written byte
   function automatic logic [7:0] expv(input logic [7:0] i, input logic [7:0] v);
      case (i)
         8'h79: return v & 8'h0f;
         8'h7a: return (v & 8'h17) | 8'he0;
         8'h7e: return v & 8'h3f;
         default: return v;
      endcase
   endfunction : expv
   task automatic wrc(input logic [7:0] i, input logic [7:0] v);
      axw(i, v, rsp);
      chk({30'h0, rsp}, 32'h0);
      mdl[i] = expv(i, v);
      rc(i, mdl[i]);
   endtask : wrc
   task automatic frm(input logic [7:0] mon, input logic mr, input logic mx);
      lnk.send({32'hffffffff, ic1, ic2, mon, ci, mr, mx});
      repeat (8) @(posedge clk);
   endtask : frm
   task automatic test_done();
      $display("Checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done
   // Watchdog against a hung handshake
   initial begin
      #300000;
      num_errors++;
      test_done();
   end
   // Main sequence
   initial begin
      logic [7:0] ri [7] = '{8'h72, 8'h73, 8'h75, 8'h76, 8'h79, 8'h7a, 8'h7e};
      logic [7:0] re [7] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'hf7, 8'h3f};
      logic [7:0] wi [5] = '{8'h72, 8'h73, 8'h7e, 8'h79, 8'h7a};
      logic [7:0] wd [5] = '{8'h00, 8'h00, 8'h00, 8'hf8, 8'h00};
      logic [31:0] v;
      repeat (10) @(posedge clk);
      rn <= 1'b1;
      @(posedge clk);
      v = $urandom(32'h1fe6);
      foreach (ri[i]) rc(ri[i], re[i]);
      axr(8'h10, v, rsp);
      chk({rsp, v[29:0]}, 32'h80000000);
      axw(8'h6e, 8'h00, rsp);
      chk({30'h0, rsp}, 32'h2);
      for (int i = 0; i < 5; i++) begin
         if (i < 3) wd[i] = 8'($urandom);
         wrc(wi[i], wd[i]);
      end
      ic1 = 8'($urandom);
      ic2 = 8'($urandom);
      ci = 6'($urandom % 63);
      frm(8'hff, 1'b1, 1'b1);
      rc(8'h6e, ic1);
      rc(8'h6f, ic2);
      rc(8'h7d, {2'b00, ci});
      chk({16'h0, lnk.du_frame[31:16]}, {16'h0, mdl[8'h72], mdl[8'h73]});
      chk({24'h0, lnk.du_frame[7:0]}, {24'h0, mdl[8'h7e][5:0], 2'b11});
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      @(posedge clk);
      rc(8'h76, 8'h07);
      rc(8'h76, 8'h00);
      chk({31'h0, irq}, 32'h0);
      m = 8'($urandom);
      frm(m, 1'b1, 1'b0);
      rc(8'h6d, m);
      rc(8'h75, 8'h08);
      rc(8'h75, 8'h00);
      rc(8'h76, 8'h16);
      wrc(8'h7a, 8'hf7);
      ci = ci ^ 6'h01;
      frm(8'hff, 1'b1, 1'b0);
      chk({31'h0, lnk.du_frame[1]}, 32'h1);
      rc(8'h76, 8'h00);
      mon0 <= 1'b1;
      @(posedge clk);
      mon0 <= 1'b0;
      rc(8'h76, 8'h08);
      // Monitor-1 send, acknowledge, end of packet and abort with both bit controls on
      wrc(8'h79, 8'h0f);
      m = 8'($urandom);
      wrc(8'h71, m);
      wrc(8'h7c, 8'h40);
      frm(8'hff, 1'b1, 1'b1);
      chk({23'h0, lnk.du_frame[15:8], lnk.du_frame[0]}, {23'h0, m, 1'b0});
      frm(8'hff, 1'b1, 1'b1);
      chk({30'h0, lnk.du_frame[1:0]}, 32'h2);
      frm(8'hff, 1'b0, 1'b1);
      rc(8'h75, 8'h06);
      rc(8'h7c, 8'h00);
      m = 8'($urandom);
      frm(m, 1'b1, 1'b0);
      rc(8'h6d, m);
      rc(8'h75, 8'h08);
      frm(8'hff, 1'b1, 1'b1);
      chk({30'h0, lnk.du_frame[1:0]}, 32'h1);
      m = 8'($urandom);
      frm(m, 1'b0, 1'b0);
      rc(8'h6d, m);
      rc(8'h75, 8'h09);
      test_done();
   end
endmodule : gax_regs_tb
